// ### core/display_list_sequencer.sv
// Purpose: Fetches and executes display list instructions per scan line
// Assumes: Memory read data arrives on the cycle after mem_rd
// Notes: Pixel generation and fine scroll shifting live elsewhere
`timescale 1ns/1ps

module display_list_sequencer #(
	parameter logic [8:0] LINES = dl_pkg::LINES_PER_FRAME
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Host pointer writes
	input wire logic list_pointer_low_wr,
	input wire logic list_pointer_high_wr,
	input wire logic [7:0] list_pointer_wdata,
	// Control bits
	input wire logic list_dma_en,
	input wire logic [1:0] playfield_width,
	input wire logic [3:0] vscroll_value,
	// Playfield fetch engine
	input wire logic pf_fetch,
	// Memory bus
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	// Status
	output logic [15:0] list_pointer,
	output logic [15:0] scan_addr,
	output logic [7:0] instruction_reg,
	output logic [3:0] row_count,
	output logic horizontal_scroll_enable,
	output logic vertical_scroll_enable,
	output logic playfield_line,
	output logic line_interrupt_request,
	output logic vblank,
	output logic vsync,
	output logic [6:0] cycle,
	output logic [8:0] line
);
	logic [15:0] ptr_r;
	logic [15:0] scan_r;
	logic [7:0] ir_r;
	logic [7:0] lo_r;
	logic [3:0] row_r;
	logic [3:0] end_row_r;
	logic need_new_r;
	logic fresh_r;
	logic wait_r;
	logic en_line_r;
	logic addr_act_r;
	logic prev_vs_r;
	logic last_line_r;
	logic bug_r;
	logic irq_r;
	logic vblank_r;
	logic vsync_r;
	logic [6:0] cyc;
	logic [8:0] ln;

	logic in_win;
	logic vbl_start;
	logic [3:0] mode;
	logic is_blank;
	logic is_jump;
	logic is_pf;
	logic vs_eff;
	logic do_ifetch;
	logic [3:0] start_row;
	logic [3:0] end_row;
	logic [3:0] next_row;
	logic [3:0] next_end;
	logic hires;
	logic pf_region;

	line_timer #(
		.CYCLES(dl_pkg::CYCLES_PER_LINE),
		.LINES(LINES)
	) u_timer (
		.clk(clk),
		.nrst(nrst),
		.cycle_r(cyc),
		.line_r(ln)
	);

	// Mode line height minus one
	function automatic logic [3:0] mode_last_row(input logic [7:0] ins);
		logic [3:0] r;
		r = 4'h0;
		case (ins[3:0])
			4'h0: r = {1'b0, ins[6:4]};
			4'h1: r = 4'h0;
			4'h2, 4'h4, 4'h6, 4'h8: r = 4'h7;
			4'h3: r = 4'h9;
			4'h5, 4'h7: r = 4'hf;
			4'h9, 4'ha: r = 4'h3;
			4'hb, 4'hd: r = 4'h1;
			default: r = 4'h0;
		endcase
		return r;
	endfunction : mode_last_row

	// Decode of current instruction
	always_comb
	begin
		mode = ir_r[3:0];
		is_blank = (mode == dl_pkg::MODE_BLANK);
		is_jump = (mode == dl_pkg::MODE_JUMP);
		is_pf = !is_blank && !is_jump;
		vs_eff = ir_r[dl_pkg::BIT_VS] && is_pf;
		in_win = (ln >= dl_pkg::FIRST_LIST_LINE) && (ln < dl_pkg::VBLANK_LINE);
		vbl_start = (ln == dl_pkg::VBLANK_LINE) && (cyc == 7'h00);
		do_ifetch = in_win && (cyc == dl_pkg::IFETCH_CYC) && need_new_r && en_line_r
			&& !wait_r;
		start_row = (vs_eff && !prev_vs_r) ? vscroll_value : 4'h0;
		end_row = (!vs_eff && prev_vs_r) ? vscroll_value : mode_last_row(ir_r);
		next_row = need_new_r ? start_row : row_r + 4'h1;
		next_end = need_new_r ? end_row : end_row_r;
		hires = (mode == 4'h2) || (mode == 4'h3) || (mode == 4'hf);
		pf_region = (cyc >= dl_pkg::PF_REGION_FIRST) && (cyc <= dl_pkg::PF_REGION_LAST);
	end

	// Memory reads of instruction and address bytes
	always_comb
	begin
		mem_rd = do_ifetch || (in_win && addr_act_r
			&& ((cyc == dl_pkg::ADDR_LO_CYC) || (cyc == dl_pkg::ADDR_HI_CYC)));
		mem_addr = ptr_r;
	end

	// List DMA enable sampled before the line
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			en_line_r <= 1'b0;
		else if (cyc == dl_pkg::EN_SAMPLE_CYC)
			en_line_r <= list_dma_en;
	end

	// Instruction pointer
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ptr_r <= dl_pkg::PTR_RESET;
		else if (list_pointer_low_wr)
			ptr_r[7:0] <= list_pointer_wdata;
		else if (list_pointer_high_wr)
			ptr_r[15:8] <= list_pointer_wdata;
		else if (in_win && addr_act_r && is_jump && cyc == dl_pkg::ADDR_LOAD_CYC)
			ptr_r <= {mem_rdata, lo_r};
		else if (mem_rd)
			ptr_r[dl_pkg::PTR_WRAP_BITS-1:0] <=
				ptr_r[dl_pkg::PTR_WRAP_BITS-1:0] + 10'h001;
	end

	// Instruction register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ir_r <= dl_pkg::IR_RESET;
		else if (vbl_start)
			ir_r[dl_pkg::BIT_LOAD] <= 1'b0;
		else if (fresh_r && cyc == dl_pkg::IR_LOAD_CYC)
			ir_r <= mem_rdata;
	end

	// Fresh fetch marker, cleared once decoded
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			fresh_r <= 1'b0;
		else if (do_ifetch)
			fresh_r <= 1'b1;
		else if (cyc == dl_pkg::DECODE_CYC)
			fresh_r <= 1'b0;
	end

	// Address byte fetch decision
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			addr_act_r <= 1'b0;
		else if (in_win && cyc == dl_pkg::DECODE_CYC)
			addr_act_r <= list_dma_en && !wait_r
				&& (is_jump || (fresh_r && is_pf && ir_r[dl_pkg::BIT_LOAD]));
		else if (cyc == dl_pkg::ADDR_LOAD_CYC)
			addr_act_r <= 1'b0;
	end

	// Low address byte holding
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			lo_r <= 8'h00;
		else if (cyc == dl_pkg::ADDR_HI_CYC && addr_act_r)
			lo_r <= mem_rdata;
	end

	// Wait for vertical blank
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wait_r <= 1'b0;
		else if (vbl_start)
			wait_r <= 1'b0;
		else if (in_win && addr_act_r && is_jump && cyc == dl_pkg::ADDR_LOAD_CYC)
			wait_r <= ir_r[dl_pkg::BIT_LOAD];
	end

	// Row counter and mode line sequencing
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			row_r <= 4'h0;
			end_row_r <= 4'h0;
			last_line_r <= 1'b0;
		end
		else if (in_win && cyc == dl_pkg::DECODE_CYC)
		begin
			row_r <= next_row;
			end_row_r <= next_end;
			last_line_r <= (next_row == next_end);
		end
	end

	// Previous vertical scroll state, kept through blank
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			prev_vs_r <= 1'b0;
		else if (in_win && cyc == dl_pkg::DECODE_CYC && need_new_r)
			prev_vs_r <= vs_eff;
	end

	// New instruction needed at line end or blank entry
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			need_new_r <= 1'b1;
		else if (vbl_start)
			need_new_r <= 1'b1;
		else if (in_win && cyc == dl_pkg::DECODE_CYC)
			need_new_r <= 1'b0;
		else if (in_win && cyc == dl_pkg::EN_SAMPLE_CYC && last_line_r)
			need_new_r <= 1'b1;
	end

	// Playfield memory scan counter
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			scan_r <= dl_pkg::PTR_RESET;
		else if (in_win && addr_act_r && is_pf && cyc == dl_pkg::ADDR_LOAD_CYC)
			scan_r <= {mem_rdata, lo_r};
		else if (pf_fetch)
			scan_r[dl_pkg::SCAN_WRAP_BITS-1:0] <=
				scan_r[dl_pkg::SCAN_WRAP_BITS-1:0] + 12'h001;
	end

	// Line interrupt on last line of a mode line
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			irq_r <= 1'b0;
		else
			irq_r <= in_win && cyc == dl_pkg::IRQ_CYC && last_line_r
				&& ir_r[dl_pkg::BIT_IRQ];
	end

	// Hi-res last line fault capture
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			bug_r <= 1'b0;
		else if (ln == dl_pkg::HIRES_BUG_LINE && cyc == dl_pkg::EN_SAMPLE_CYC)
			bug_r <= hires && (playfield_width != 2'h0);
		else if (ln == dl_pkg::FIRST_LIST_LINE && cyc == 7'h00)
			bug_r <= 1'b0;
	end

	// Blank and sync outputs
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			vblank_r <= 1'b1;
			vsync_r <= 1'b0;
		end
		else
		begin
			vblank_r <= !in_win && !(bug_r && pf_region);
			vsync_r <= (ln >= dl_pkg::VSYNC_FIRST) && (ln <= dl_pkg::VSYNC_LAST)
				&& !(bug_r && pf_region);
		end
	end

	// Status outputs
	always_comb
	begin
		list_pointer = ptr_r;
		scan_addr = scan_r;
		instruction_reg = ir_r;
		row_count = row_r;
		horizontal_scroll_enable = ir_r[dl_pkg::BIT_HS] && is_pf;
		vertical_scroll_enable = vs_eff;
		playfield_line = is_pf && !vblank_r;
		line_interrupt_request = irq_r;
		vblank = vblank_r;
		vsync = vsync_r;
		cycle = cyc;
		line = ln;
	end
endmodule : display_list_sequencer

// ### core/dl_pkg.sv
// Purpose: Shared constants for the display list sequencer
// Assumes: One machine cycle per clk edge, 114 cycles per scan line
// Notes: Cycle slots below place every list fetch inside one scan line
//
// Operation
// - Only the low ten instruction pointer bits count; fetches wrap inside 1K.
// - Writes to either pointer byte steer the very next instruction fetch.
// - Mode values 2 to F are playfield lines showing fetched data.
// - Bit 6 on a playfield line loads the scan pointer, low byte first.
// - Scan counter wraps within its 4K block when fetches cross the boundary.
// - Mode 0000 is blank; bits 6..4 give 1 to 8 scan lines.
// - Blank lines never scroll and never load the scan address.
// - Mode 0001 jumps via two following bytes, low first, showing one blank line.
// - Jumps ignore scroll bits; lines added by scroll end refetch the address.
// - Jumps honour the interrupt request bit like other instructions.
// - Jump with bit 6 loads pointer, then replays each line until vertical blank.
// - Waiting jump interrupts every replay line; first line height follows scroll end.
// - Waiting jump loads the pointer on its first line; later writes replace it.
// - Only vertical blank restarts fetching after a waiting jump.
// - List runs from line 8 to line 247, suspended and resumed there.
// - Previous vertical scroll state is kept across vertical blank.
// - A mode line running into vertical blank is cut short.
// - With list DMA off the last instruction repeats without address loads.
// - Instruction bit 6 is cleared during vertical blank.
// - Instruction fetch on cycle 1; enable must arrive by cycle 113 before.
// - Hi-res line 247 with nonzero width blocks blank and sync in playfield.

package dl_pkg;
	localparam int CYC_W = 7;
	localparam int LINE_W = 9;
	localparam logic [6:0] CYCLES_PER_LINE = 7'h72;
	localparam logic [8:0] LINES_PER_FRAME = 9'h106;
	localparam logic [8:0] FIRST_LIST_LINE = 9'h008;
	localparam logic [8:0] VBLANK_LINE = 9'h0f8;
	localparam logic [8:0] HIRES_BUG_LINE = 9'h0f7;
	localparam logic [8:0] VSYNC_FIRST = 9'h0fb;
	localparam logic [8:0] VSYNC_LAST = 9'h0fd;
	localparam logic [6:0] IFETCH_CYC = 7'h01;
	localparam logic [6:0] IR_LOAD_CYC = 7'h02;
	localparam logic [6:0] DECODE_CYC = 7'h03;
	localparam logic [6:0] ADDR_LO_CYC = 7'h04;
	localparam logic [6:0] ADDR_HI_CYC = 7'h05;
	localparam logic [6:0] ADDR_LOAD_CYC = 7'h06;
	localparam logic [6:0] IRQ_CYC = 7'h6e;
	localparam logic [6:0] EN_SAMPLE_CYC = 7'h71;
	localparam logic [6:0] PF_REGION_FIRST = 7'h10;
	localparam logic [6:0] PF_REGION_LAST = 7'h68;
	localparam int BIT_IRQ = 7;
	localparam int BIT_LOAD = 6;
	localparam int BIT_VS = 5;
	localparam int BIT_HS = 4;
	localparam int PTR_WRAP_BITS = 10;
	localparam int SCAN_WRAP_BITS = 12;
	localparam logic [3:0] MODE_BLANK = 4'h0;
	localparam logic [3:0] MODE_JUMP = 4'h1;
	localparam logic [7:0] IR_RESET = 8'h00;
	localparam logic [15:0] PTR_RESET = 16'h0000;
endpackage : dl_pkg

// ### core/line_timer.sv
// Purpose: Machine cycle and scan line counters
// Assumes: Counts wrap at the line and frame lengths
// Notes: Both counters reset to zero
`timescale 1ns/1ps

module line_timer #(
	parameter logic [6:0] CYCLES = dl_pkg::CYCLES_PER_LINE,
	parameter logic [8:0] LINES = dl_pkg::LINES_PER_FRAME
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Position
	output logic [6:0] cycle_r,
	output logic [8:0] line_r
);
	// Cycle within line
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cycle_r <= 7'h00;
		else if (cycle_r == CYCLES - 7'h01)
			cycle_r <= 7'h00;
		else
			cycle_r <= cycle_r + 7'h01;
	end

	// Line within frame
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			line_r <= 9'h000;
		else if (cycle_r == CYCLES - 7'h01)
		begin
			if (line_r == LINES - 9'h001)
				line_r <= 9'h000;
			else
				line_r <= line_r + 9'h001;
		end
	end
endmodule : line_timer

// ### dv/dl_seq_checker_assertions.sv
// Purpose: Port checks of the display list sequencer
// Assumes: Cycle slots as set in dl_pkg
// Notes: Bound to every sequencer instance
`timescale 1ns/1ps

module dl_seq_checker #(
	parameter logic [8:0] LINES = dl_pkg::LINES_PER_FRAME
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Inputs
	input wire logic list_pointer_low_wr,
	input wire logic list_pointer_high_wr,
	input wire logic [7:0] list_pointer_wdata,
	input wire logic pf_fetch,
	// Outputs
	input wire logic mem_rd,
	input wire logic [15:0] list_pointer,
	input wire logic [15:0] scan_addr,
	input wire logic [7:0] instruction_reg,
	input wire logic horizontal_scroll_enable,
	input wire logic vertical_scroll_enable,
	input wire logic playfield_line,
	input wire logic line_interrupt_request,
	input wire logic vblank,
	input wire logic [6:0] cycle,
	input wire logic [8:0] line
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_fetch_slot: assert property (mem_rd |-> cycle == 7'h01 || cycle == 7'h04 || cycle == 7'h05)
		else $error("read outside fetch slots");
	a_fetch_range: assert property (mem_rd |-> line >= 9'h008 && line < 9'h0f8)
		else $error("read outside list lines");
	a_ptr_wrap: assert property ((mem_rd && cycle == 7'h01 && !list_pointer_low_wr
		&& !list_pointer_high_wr) |=> list_pointer[9:0] == $past(list_pointer[9:0]) + 10'h1
		&& list_pointer[15:10] == $past(list_pointer[15:10]))
		else $error("pointer step wrong");
	a_write_low: assert property (list_pointer_low_wr |=> list_pointer[7:0] == $past(list_pointer_wdata))
		else $error("low pointer write lost");
	a_write_high: assert property (list_pointer_high_wr && !list_pointer_low_wr
		|=> list_pointer[15:8] == $past(list_pointer_wdata))
		else $error("high pointer write lost");
	a_blank_quiet: assert property (instruction_reg[3:1] == 3'h0 |-> !horizontal_scroll_enable
		&& !vertical_scroll_enable && !playfield_line)
		else $error("blank or jump line scrolls");
	a_scroll_bits: assert property (instruction_reg[3:1] != 3'h0 |-> horizontal_scroll_enable
		== instruction_reg[4] && vertical_scroll_enable == instruction_reg[5])
		else $error("scroll flags differ from instruction");
	a_irq_slot: assert property (line_interrupt_request |-> instruction_reg[7] && cycle == 7'h6f
		##1 !line_interrupt_request)
		else $error("line interrupt misplaced");
	a_vblank_window: assert property (cycle == 7'h07 |-> vblank == (line < 9'h008 || line >= 9'h0f8))
		else $error("vblank window wrong");
	a_scan_wrap: assert property (pf_fetch && cycle >= 7'h10 |=> scan_addr[11:0]
		== $past(scan_addr[11:0]) + 12'h1 && scan_addr[15:12] == $past(scan_addr[15:12]))
		else $error("scan counter step wrong");
endmodule : dl_seq_checker

bind display_list_sequencer dl_seq_checker #(.LINES(LINES)) chk (
	.clk(clk),
	.nrst(nrst),
	.list_pointer_low_wr(list_pointer_low_wr),
	.list_pointer_high_wr(list_pointer_high_wr),
	.list_pointer_wdata(list_pointer_wdata),
	.pf_fetch(pf_fetch),
	.mem_rd(mem_rd),
	.list_pointer(list_pointer),
	.scan_addr(scan_addr),
	.instruction_reg(instruction_reg),
	.horizontal_scroll_enable(horizontal_scroll_enable),
	.vertical_scroll_enable(vertical_scroll_enable),
	.playfield_line(playfield_line),
	.line_interrupt_request(line_interrupt_request),
	.vblank(vblank),
	.cycle(cycle),
	.line(line)
);

// ### dv/mem_model.sv
// Purpose: System memory answering list fetches
// Assumes: Data due one cycle after a read
// Notes: Between reads the data lines toggle
`timescale 1ns/1ps

module mem_model (
	// Clock
	input wire logic clk,
	// Memory bus
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	initial
	begin
		mem_rdata = 8'h5a;
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	always @(posedge clk)
		if (mem_rd === 1'b1)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
endmodule : mem_model

// ### dv/tb.sv
// Purpose: Self-checking bench of the display list sequencer
// Assumes: Short frames of 252 lines
// Notes: Random pointer writes precede the list run
`timescale 1ns/1ps

module tb;
	logic clk = 1'b0, nrst = 1'b0, list_dma_en = 1'b0, pf_fetch = 1'b0;
	logic list_pointer_low_wr = 1'b0, list_pointer_high_wr = 1'b0;
	logic [7:0] list_pointer_wdata = 8'h00, mem_rdata, instruction_reg;
	logic [1:0] playfield_width = 2'h0;
	logic [3:0] vscroll_value = 4'h0;
	logic mem_rd, hse, vse, playfield_line, line_interrupt_request, vblank, vsync;
	logic [15:0] mem_addr, list_pointer, scan_addr;
	logic [3:0] row_count;
	logic [6:0] cycle;
	logic [8:0] line;
	int err_total = 0, n_compared = 0, rd_cnt = 0, rd_mark = 0;
	logic [31:0] seed = 32'h6369781a;
	logic [15:0] exp_ptr = 16'h0000;
	logic [15:0] dl_a [11] = '{16'h07fe, 16'h07ff, 16'h0400, 16'h0401, 16'h0402,
		16'h0403, 16'h0404, 16'h0600, 16'h0601, 16'h0602, 16'h0500};
	logic [7:0] dl_d [11] = '{8'h42, 8'hfe, 8'h1f, 8'h70, 8'h81, 8'h00, 8'h06, 8'hc1, 8'hfe, 8'h07,
		8'h03};

	display_list_sequencer #(.LINES(9'h0fc)) dut (.clk(clk), .nrst(nrst),
		.list_pointer_low_wr(list_pointer_low_wr), .list_pointer_high_wr(list_pointer_high_wr),
		.list_pointer_wdata(list_pointer_wdata), .list_dma_en(list_dma_en),
		.playfield_width(playfield_width), .vscroll_value(vscroll_value), .pf_fetch(pf_fetch),
		.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .list_pointer(list_pointer),
		.scan_addr(scan_addr), .instruction_reg(instruction_reg), .row_count(row_count),
		.horizontal_scroll_enable(hse), .vertical_scroll_enable(vse),
		.playfield_line(playfield_line), .line_interrupt_request(line_interrupt_request),
		.vblank(vblank), .vsync(vsync), .cycle(cycle), .line(line));
	mem_model mem_i (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

	always #25 clk = ~clk;
	always @(posedge clk)
		if (mem_rd === 1'b1)
			rd_cnt <= rd_cnt + 1;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	task automatic wait_pos(input logic [8:0] l, input logic [6:0] c);
		for (int n = 0; n < 40000; n++)
		begin
			@(posedge clk);
			#1;
			if (line === l && cycle === c)
				return;
		end
		err_total++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, line, l);
		final_report();
	endtask : wait_pos

	task automatic wr_ptr(input logic hi, input logic [7:0] d);
		@(posedge clk);
		list_pointer_high_wr <= hi;
		list_pointer_low_wr <= !hi;
		list_pointer_wdata <= d;
		@(posedge clk);
		list_pointer_high_wr <= 1'b0;
		list_pointer_low_wr <= 1'b0;
		if (hi)
			exp_ptr[15:8] = d;
		else
			exp_ptr[7:0] = d;
		#1;
		chk(list_pointer, exp_ptr);
	endtask : wr_ptr

	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		foreach (dl_a[i])
			mem_i.mem[dl_a[i]] = dl_d[i];
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			@(posedge clk);
			playfield_width <= seed[1:0];
			vscroll_value <= seed[12:9];
			wr_ptr(seed[8], seed[7:0]);
		end
		wr_ptr(1'b0, 8'hfe);
		wr_ptr(1'b1, 8'h07);
		@(posedge clk);
		list_dma_en <= 1'b1;
		$display("test done: pointer writes");
		wait_pos(9'h008, 7'h07);
		chk(16'(instruction_reg), 16'h0042);
		chk(16'(playfield_line), 16'h0001);
		chk(scan_addr, 16'h1ffe);
		chk(list_pointer, 16'h0401);
		wait_pos(9'h008, 7'h14);
		@(posedge clk);
		pf_fetch <= 1'b1;
		repeat (3) @(posedge clk);
		pf_fetch <= 1'b0;
		#1;
		chk(scan_addr, 16'h1001);
		$display("test done: mode line and scan load");
		wait_pos(9'h010, 7'h07);
		chk({13'h0000, playfield_line, vse, hse}, 16'h0000);
		wait_pos(9'h017, 7'h07);
		chk(16'(instruction_reg), 16'h0070);
		wait_pos(9'h018, 7'h07);
		chk(16'(instruction_reg), 16'h0081);
		chk(list_pointer, 16'h0600);
		wait_pos(9'h018, 7'h6f);
		chk(16'(line_interrupt_request), 16'h0001);
		wait_pos(9'h019, 7'h07);
		chk(list_pointer, 16'h07fe);
		rd_mark = rd_cnt;
		wait_pos(9'h01a, 7'h6f);
		chk(16'(line_interrupt_request), 16'h0001);
		wait_pos(9'h028, 7'h07);
		chk(16'(rd_cnt), 16'(rd_mark));
		wr_ptr(1'b0, 8'h00);
		wr_ptr(1'b0, 8'hfe);
		$display("test done: jumps");
		wait_pos(9'h0fa, 7'h07);
		chk(16'(vblank), 16'h0001);
		chk(16'(instruction_reg), 16'h0081);
		@(posedge clk);
		list_dma_en <= 1'b0;
		rd_mark = rd_cnt;
		wait_pos(9'h008, 7'h07);
		chk(16'(instruction_reg), 16'h0081);
		chk(list_pointer, 16'h07fe);
		chk(16'(rd_cnt), 16'(rd_mark));
		chk(16'(vblank), 16'h0000);
		$display("test done: blank and dma off");
		wr_ptr(1'b0, 8'h00);
		wr_ptr(1'b1, 8'h05);
		@(posedge clk);
		list_dma_en <= 1'b1;
		wait_pos(9'h009, 7'h07);
		chk(16'(instruction_reg), 16'h0003);
		chk(list_pointer, 16'h0501);
		@(posedge clk);
		list_dma_en <= 1'b0;
		playfield_width <= 2'h1;
		wait_pos(9'h0f7, 7'h07);
		chk(16'(row_count), 16'h0008);
		chk(16'(instruction_reg), 16'h0003);
		wait_pos(9'h0f8, 7'h20);
		chk(16'(vblank), 16'h0000);
		wait_pos(9'h0fb, 7'h07);
		chk(16'(vsync), 16'h0001);
		wait_pos(9'h0fb, 7'h20);
		chk(16'(vsync), 16'h0000);
		wait_pos(9'h008, 7'h07);
		chk(16'(row_count), 16'h0000);
		chk(16'(instruction_reg), 16'h0003);
		$display("test done: hi-res last line");
		final_report();
	end
endmodule : tb
